// [mws_motion_word.v]
// motion command decoder, state word builder and safe stop sequencer
`timescale 1ns/10ps
`include "mws_defs.vh"
module mws_motion_word #(
  parameter PW        = 32,               // position width
  parameter SW        = 16,               // speed width
  parameter STOP_CYC  = `MWS_STOP_TIME_CYC
) (
  // clock and reset
  input  wire          SYS_CLK,
  input  wire          RESETN,
  // word interface
  input  wire [15:0]   COMMAND_WORD,
  output reg  [15:0]   STATE_WORD,
  // configuration
  input  wire [1:0]    PROFILE_SEL,
  input  wire [27:0]   CMD_SLOT_SEL,     // 7 slots x 4 bits
  input  wire [14:0]   STATE_SLOT_SEL,   // 5 slots x 3 bits
  input  wire          SS_VARIANT,
  input  wire          SLS_RAMP_EN,
  input  wire          SMS_EN,
  input  wire          BUS_CONTROL,
  // safety requests
  input  wire          TORQUE_OFF_REQ,
  input  wire          CTRL_STOP_REQ,
  input  wire          SLS_REQ,
  // drive state
  input  wire          CONTROL_READY,
  input  wire          DRIVE_READY,
  input  wire          TRIP,
  input  wire          TRIP_LOCK,
  input  wire          WARNING,
  input  wire          AUTO_START_STOP,
  input  wire          VOLT_EXCEED,
  input  wire          TORQUE_EXCEED,
  input  wire          TIMER_EXCEED,
  input  wire          HOMING_COMPLETE,
  input  wire          SYNC_MODE,
  input  wire          SYNC_ALIGNED,
  // positions and speeds
  input  wire [PW-1:0] TARGET_POS,
  input  wire [PW-1:0] AXIS_POS,
  input  wire [PW-1:0] POS_MIN,
  input  wire [PW-1:0] POS_MAX,
  input  wire [PW-1:0] TRACK_ERR,
  input  wire [PW-1:0] MAX_POS_ERR,
  input  wire [SW-1:0] RAMP_SPEED_REF,
  input  wire [SW-1:0] MOTOR_SPEED,
  input  wire [SW-1:0] SLS_LIMIT,
  input  wire [SW-1:0] SMS_LIMIT,
  input  wire [SW-1:0] FREQ_OUT,
  input  wire [SW-1:0] FREQ_LOW,
  input  wire [SW-1:0] FREQ_HIGH,
  input  wire          VMASTER_DIR,
  // decoded commands
  output reg  [2:0]    PRESET_REF,
  output reg  [1:0]    SETUP_SEL,
  output reg           RUN_ENABLE,
  output reg           JOG,
  output reg           QUICK_STOP,
  output reg           FAULT_RESET,
  output reg           RELATIVE_POS,
  output reg           DATA_VALID,
  output reg           REVERSE,
  output reg  [11:0]   AUX_FUNC,
  output reg  [PW-1:0] EFF_TARGET,
  // discrete status
  output reg           HOMING_DONE,
  output reg           ON_TARGET,
  output reg           POS_ERROR,
  output reg           POS_LIMIT,
  output reg           TOUCH_ON_TARGET,
  output reg           TOUCH_ACTIVE,
  output reg           REVERSE_AFTER_RAMP,
  output reg           VMASTER_DIR_OUT,
  // motor power stage
  output reg           MOTOR_OUT_EN,
  output reg           RAMP_DOWN,
  output reg           TORQUE_OFF
);
  // safe stop sequencer overview:
  //   run  - power stage energised, commands obeyed
  //   ramp - power kept, speed brought down under control
  //   off  - power cut at once, motor coasts
  //   idle - power still cut, waiting for start to drop
  // the idle step stops a start bit that was held through a
  // trip from re-energising the motor by itself; the master
  // must take start low before the drive runs again
  // reset lands in off, so power is never on at wake-up
  // guards are compared on speed magnitude, so direction
  // does not matter; the most negative speed reads as large
  // limitation: the ramp itself is done by the speed loop,
  // this block only asks for it and watches the outcome
  // sequencer states, one-hot
  localparam ST_RUN  = 4'b0001;
  localparam ST_RAMP = 4'b0010;
  localparam ST_OFF  = 4'b0100;
  localparam ST_IDLE = 4'b1000;

  reg          rst_s1, rst_n;            // reset release chain
  reg  [3:0]   state, next_state;        // stop sequencer
  reg  [31:0]  stop_cnt;                 // time-based stop timer
  reg  [11:0]  next_aux;                 // reassigned functions
  reg          touch_sel;                // touch probe request
  reg          homing_req;               // homing request
  reg          inv_req;                  // target inversion
  wire         motion;                   // motion profile active
  wire         coast_cmd;                // coast from word
  wire         speed_stop;               // motor at standstill
  wire         sls_over, sms_over;       // guard comparisons
  wire [SW-1:0] spd_abs;                 // speed magnitude
  wire [4:0]   slot_bit;                 // reassigned state bits
  wire [4:0]   slot_dflt;                // default state bits
  wire         pos_err_w, pos_lim_w;
  integer      i;

  // reset released through two flops
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  assign motion     = (PROFILE_SEL == `MWS_PROF_MOTION); // RULE_01
  assign coast_cmd  = !COMMAND_WORD[`MWS_CW_NO_COAST];   // RULE_02
  // magnitude of signed motor speed
  assign spd_abs    = MOTOR_SPEED[SW-1] ? (~MOTOR_SPEED + 1'b1)
                                        : MOTOR_SPEED;
  assign speed_stop = (spd_abs == {SW{1'b0}});
  assign sls_over   = SLS_REQ && (spd_abs > SLS_LIMIT);  // RULE_19
  assign sms_over   = SMS_EN && (spd_abs > SMS_LIMIT);   // RULE_21
  // tracking error and limits, signed compare
  assign pos_err_w  = $signed(TRACK_ERR) > $signed(MAX_POS_ERR); // RULE_13
  assign pos_lim_w  = ($signed(AXIS_POS) <= $signed(POS_MIN)) ||
                      ($signed(AXIS_POS) >= $signed(POS_MAX)); // RULE_14

  // reassignable command slots: bits 0-2 then 12-15
  always @* begin
    next_aux   = 12'h000;
    touch_sel  = 1'b0;
    homing_req = 1'b0;
    inv_req    = 1'b0;
    for (i = 0; i < 7; i = i + 1) begin
      if (COMMAND_WORD[(i < 3) ? i : i + 9]) begin
        case (CMD_SLOT_SEL[i*4 +: 4])                    // RULE_04
          `MWS_CF_HOMING:     homing_req   = 1'b1;
          `MWS_CF_TOUCH:      touch_sel    = 1'b1;
          `MWS_CF_SYNC_POS:   next_aux[0]  = 1'b1;
          `MWS_CF_RAMP2:      next_aux[1]  = 1'b1;
          `MWS_CF_RELAY1:     next_aux[2]  = 1'b1;
          `MWS_CF_RELAY2:     next_aux[3]  = 1'b1;
          `MWS_CF_SPEED_MODE: next_aux[4]  = 1'b1;
          `MWS_CF_VMASTER:    next_aux[5]  = 1'b1;
          `MWS_CF_MOFFSET:    next_aux[6]  = 1'b1;
          `MWS_CF_TGT_INV:    inv_req      = 1'b1;
          `MWS_CF_HOME_SENS:  next_aux[7]  = 1'b1;
          `MWS_CF_TOUCH_SENS: next_aux[8]  = 1'b1;
          default:            next_aux[11] = next_aux[11];
        endcase
      end
    end
    // default meanings of fixed bits in motion profile
    if (motion) begin
      if (COMMAND_WORD[`MWS_CW_HOMING])
        homing_req = 1'b1;                               // RULE_03
      if (CMD_SLOT_SEL[12 +: 4] == `MWS_CF_DEFAULT &&
          COMMAND_WORD[`MWS_CW_TOUCH])
        touch_sel = 1'b1;
    end
    next_aux[9]  = homing_req;
    next_aux[10] = touch_sel;
    next_aux[11] = inv_req;
  end

  // stop sequencer next state
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        // any over-limit wins over a ramp request
        if (TORQUE_OFF_REQ || sls_over || sms_over)
          next_state = ST_OFF;                           // RULE_16
        // speed guard with ramp-down ramps on activation
        else if (CTRL_STOP_REQ || (SLS_REQ && SLS_RAMP_EN))
          next_state = ST_RAMP;                          // RULE_20
      end
      ST_RAMP: begin
        // guards still supervise while ramping
        if (TORQUE_OFF_REQ || sls_over || sms_over)
          next_state = ST_OFF;
        else if (SS_VARIANT == `MWS_SS_RAMP ? speed_stop
                 : (stop_cnt >= STOP_CYC - 1))
          next_state = ST_OFF;                           // RULE_17 RULE_18
      end
      ST_OFF: begin
        if (!TORQUE_OFF_REQ && !CTRL_STOP_REQ && !sls_over &&
            !sms_over && speed_stop)
          next_state = ST_IDLE;
      end
      ST_IDLE: begin
        // re-arming needs start released first
        // a guard over its limit keeps the power cut
        if (TORQUE_OFF_REQ || sls_over || sms_over)
          next_state = ST_OFF;
        else if (!COMMAND_WORD[`MWS_CW_START] &&
                 !COMMAND_WORD[`MWS_CW_JOG])
          next_state = ST_RUN;                           // RULE_22
      end
      default: next_state = ST_OFF;
    endcase
  end

  // sequencer state and stop timer
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_OFF;
      stop_cnt <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (state == ST_RAMP)
        stop_cnt <= stop_cnt + 32'h0000_0001;
      else
        stop_cnt <= 32'h0000_0000;
    end
  end

  // five reassignable state slots: bit 5 then 12-15
  assign slot_dflt = {TIMER_EXCEED, TORQUE_EXCEED, VOLT_EXCEED,
                      AUTO_START_STOP, 1'b0};
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_slot
      mws_slot_mux u_slot (
        .sel       (STATE_SLOT_SEL[g*3 +: 3]),
        .dflt      (slot_dflt[g]),
        .pos_err   (pos_err_w),
        .pos_lim   (pos_lim_w),
        .touch_tgt (TOUCH_ON_TARGET),
        .touch_act (TOUCH_ACTIVE),
        .bit_out   (slot_bit[g])
      );
    end
  endgenerate

  // registered command decode, status and power control
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PRESET_REF         <= 3'h0;
      SETUP_SEL          <= 2'h0;
      RUN_ENABLE         <= 1'b0;
      JOG                <= 1'b0;
      QUICK_STOP         <= 1'b0;
      FAULT_RESET        <= 1'b0;
      RELATIVE_POS       <= 1'b0;
      DATA_VALID         <= 1'b0;
      REVERSE            <= 1'b0;
      AUX_FUNC           <= 12'h000;
      EFF_TARGET         <= {PW{1'b0}};
      HOMING_DONE        <= 1'b0;
      ON_TARGET          <= 1'b0;
      POS_ERROR          <= 1'b0;
      POS_LIMIT          <= 1'b0;
      TOUCH_ON_TARGET    <= 1'b0;
      TOUCH_ACTIVE       <= 1'b0;
      REVERSE_AFTER_RAMP <= 1'b0;
      VMASTER_DIR_OUT    <= 1'b0;
      MOTOR_OUT_EN       <= 1'b0;
      RAMP_DOWN          <= 1'b0;
      TORQUE_OFF         <= 1'b1;
      STATE_WORD         <= 16'h0000;
    end else begin
      // fixed command fields
      PRESET_REF   <= COMMAND_WORD[2:0];                 // RULE_02
      SETUP_SEL    <= COMMAND_WORD[`MWS_CW_SETUP_LO +: 2]; // RULE_03
      QUICK_STOP   <= !COMMAND_WORD[`MWS_CW_NO_QSTOP];
      FAULT_RESET  <= COMMAND_WORD[`MWS_CW_RESET];
      RELATIVE_POS <= motion & COMMAND_WORD[`MWS_CW_RELATIVE];
      DATA_VALID   <= COMMAND_WORD[`MWS_CW_VALID];
      REVERSE      <= COMMAND_WORD[`MWS_CW_REVERSE];
      AUX_FUNC     <= next_aux;
      // no run while torque is off; next state is used so run
      // drops on the same edge at which torque off rises
      RUN_ENABLE   <= (next_state == ST_RUN) & !coast_cmd &
                      COMMAND_WORD[`MWS_CW_START] &
                      (!motion | COMMAND_WORD[`MWS_CW_EN_REF]); // RULE_22
      JOG          <= (next_state == ST_RUN) & !coast_cmd &
                      COMMAND_WORD[`MWS_CW_JOG];         // RULE_22
      // target sign inversion
      EFF_TARGET   <= inv_req ? (~TARGET_POS + 1'b1)
                              : TARGET_POS;              // RULE_05
      // discrete status
      HOMING_DONE  <= HOMING_COMPLETE;                   // RULE_07
      ON_TARGET    <= SYNC_MODE ? SYNC_ALIGNED
                    : (AXIS_POS == EFF_TARGET);          // RULE_08
      POS_ERROR    <= pos_err_w;                         // RULE_13
      POS_LIMIT    <= pos_lim_w;                         // RULE_14
      TOUCH_ACTIVE <= touch_sel;                         // RULE_15
      TOUCH_ON_TARGET <= touch_sel & (AXIS_POS == EFF_TARGET); // RULE_15
      REVERSE_AFTER_RAMP <= RAMP_SPEED_REF[SW-1];        // RULE_11
      VMASTER_DIR_OUT    <= VMASTER_DIR;                 // RULE_12
      // power stage: off cuts at once, ramp keeps power
      // taken from next state so the cut costs one edge only
      // enable and torque off are exact opposites by design
      TORQUE_OFF   <= (next_state == ST_OFF) ||
                      (next_state == ST_IDLE);           // RULE_16
      RAMP_DOWN    <= (next_state == ST_RAMP);           // RULE_17
      MOTOR_OUT_EN <= (next_state == ST_RUN) ||
                      (next_state == ST_RAMP);
      // state word composition
      STATE_WORD[0]  <= CONTROL_READY;                   // RULE_06
      STATE_WORD[1]  <= DRIVE_READY;
      STATE_WORD[2]  <= !coast_cmd && (state == ST_RUN);
      STATE_WORD[3]  <= TRIP;
      STATE_WORD[4]  <= motion & HOMING_COMPLETE;        // RULE_07
      STATE_WORD[5]  <= slot_bit[0];                     // RULE_10
      STATE_WORD[6]  <= TRIP_LOCK;
      STATE_WORD[7]  <= WARNING;
      STATE_WORD[8]  <= motion & (SYNC_MODE ? SYNC_ALIGNED
                        : (AXIS_POS == EFF_TARGET));     // RULE_08
      STATE_WORD[9]  <= BUS_CONTROL;
      STATE_WORD[10] <= (FREQ_OUT >= FREQ_LOW) &&
                        (FREQ_OUT <= FREQ_HIGH);         // RULE_09
      STATE_WORD[11] <= RUN_ENABLE;
      STATE_WORD[15:12] <= slot_bit[4:1];                // RULE_10
    end
  end
endmodule // mws_motion_word

// [mws_defs.vh]
// constants and field positions of the motion word and safe stop block
// Function
// RULE_01 - motion profile selects motion bit meanings
// RULE_02 - command bits 0-8: preset, coast, quick, run
// RULE_03 - command bits 9-15: relative, valid, homing, setup
// RULE_04 - command bits 0-2, 12-15 reassignable
// RULE_05 - target inversion negates configured target
// RULE_06 - state word basic status bits
// RULE_07 - bit 4 and output show homing done
// RULE_08 - bit 8 and output show on target
// RULE_09 - bit 10 shows frequency within limits
// RULE_10 - state bits 5, 12-15 reassignable
// RULE_11 - output shows negative ramped speed reference
// RULE_12 - output carries virtual master direction
// RULE_13 - position error flag on excess tracking
// RULE_14 - position limit at min or max
// RULE_15 - touch on target and touch active flags
// RULE_16 - torque off cuts output immediately
// RULE_17 - controlled stop ramps then torque off
// RULE_18 - controlled stop ramp or time variant
// RULE_19 - speed limit guard trips torque off
// RULE_20 - speed guard with or without ramp-down
// RULE_21 - max speed guard runs without input
// RULE_22 - torque off blocks re-energising commands
`ifndef MWS_DEFS_VH
`define MWS_DEFS_VH
// profile selection codes
`define MWS_PROF_DEFAULT     2'h0
`define MWS_PROF_MOTION      2'h3
// command word bit positions
`define MWS_CW_NO_COAST      3
`define MWS_CW_NO_QSTOP      4
`define MWS_CW_EN_REF        5
`define MWS_CW_START         6
`define MWS_CW_RESET         7
`define MWS_CW_JOG           8
`define MWS_CW_RELATIVE      9
`define MWS_CW_VALID         10
`define MWS_CW_HOMING        11
`define MWS_CW_TOUCH         12
`define MWS_CW_SETUP_LO      13
`define MWS_CW_REVERSE       15
// reassignable command functions
`define MWS_CF_DEFAULT       4'h0
`define MWS_CF_HOMING        4'hB
`define MWS_CF_TOUCH         4'hC
`define MWS_CF_SYNC_POS      4'hD
`define MWS_CF_RAMP2         4'hE
`define MWS_CF_RELAY1        4'hF
`define MWS_CF_RELAY2        4'h1
`define MWS_CF_SPEED_MODE    4'h2
`define MWS_CF_VMASTER       4'h3
`define MWS_CF_MOFFSET       4'h4
`define MWS_CF_TGT_INV       4'h5
`define MWS_CF_HOME_SENS     4'h6
`define MWS_CF_TOUCH_SENS    4'h7
// reassignable state functions
`define MWS_SF_DEFAULT       3'h0
`define MWS_SF_POS_ERR       3'h4
`define MWS_SF_POS_LIM       3'h5
`define MWS_SF_TOUCH_TGT     3'h6
`define MWS_SF_TOUCH_ACT     3'h7
// controlled stop variants
`define MWS_SS_RAMP          1'b0
`define MWS_SS_TIME          1'b1
// ramp timing
`define MWS_RAMP_STEP_NS     1000
`define MWS_RAMP_STEP_CYC    (`MWS_RAMP_STEP_NS / 10)
`define MWS_STOP_TIME_MS     100
`define MWS_STOP_TIME_CYC    ((`MWS_STOP_TIME_MS * 1000000) / 10)
`endif

// [mws_slot_mux.v]
// one reassignable state word slot
`timescale 1ns/10ps
module mws_slot_mux (
  // selection
  input wire [2:0] sel,
  input wire       dflt,
  // candidate flags
  input wire       pos_err,
  input wire       pos_lim,
  input wire       touch_tgt,
  input wire       touch_act,
  // result
  output reg       bit_out
);
`include "mws_defs.vh"
  // pick the flag for this slot
  always @* begin
    case (sel)
      `MWS_SF_POS_ERR:   bit_out = pos_err;   // RULE_10
      `MWS_SF_POS_LIM:   bit_out = pos_lim;
      `MWS_SF_TOUCH_TGT: bit_out = touch_tgt;
      `MWS_SF_TOUCH_ACT: bit_out = touch_act;
      default:           bit_out = dflt;
    endcase
  end
endmodule // mws_slot_mux

// [mws_motion_word_sva.sv]
// assertion checker for the motion word and safe stop block
`timescale 1ns/10ps
module mws_motion_word_sva #(
  parameter SW = 16
) (
  // clock and reset
  input wire          SYS_CLK,
  input wire          RESETN,
  // requests and configuration
  input wire          TORQUE_OFF_REQ,
  input wire          CTRL_STOP_REQ,
  input wire          SLS_REQ,
  input wire          SLS_RAMP_EN,
  input wire          SMS_EN,
  input wire [1:0]    PROFILE_SEL,
  input wire          HOMING_COMPLETE,
  input wire          VMASTER_DIR,
  input wire [SW-1:0] RAMP_SPEED_REF,
  input wire [SW-1:0] MOTOR_SPEED,
  input wire [SW-1:0] SLS_LIMIT,
  input wire [SW-1:0] SMS_LIMIT,
  // observed outputs
  input wire [15:0]   STATE_WORD,
  input wire          RUN_ENABLE,
  input wire          JOG,
  input wire          HOMING_DONE,
  input wire          REVERSE_AFTER_RAMP,
  input wire          VMASTER_DIR_OUT,
  input wire          MOTOR_OUT_EN,
  input wire          RAMP_DOWN,
  input wire          TORQUE_OFF
);
  // outputs lag the release by the reset synchroniser, so wait it out
  logic [2:0] live_cnt;
  wire        live = (live_cnt == 3'h6);
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) live_cnt <= 3'h0;
    else if (!live) live_cnt <= live_cnt + 3'h1;
  end
  default clocking dcb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN || !live);
  // controlled stop: ramp first, torque off only afterwards
  sequence stop_begin;
    $rose(CTRL_STOP_REQ) && MOTOR_OUT_EN && !TORQUE_OFF_REQ;
  endsequence
  sequence ramp_then_off;
    (RAMP_DOWN && !TORQUE_OFF) ##[1:40] TORQUE_OFF;
  endsequence
  AST_STOP_SEQ: assert property (stop_begin |=> ramp_then_off)
    else $error("controlled stop order broken");
  AST_STO_NOW: assert property (TORQUE_OFF_REQ |=> TORQUE_OFF && !MOTOR_OUT_EN)
    else $error("torque off not immediate");
  AST_STO_HOLD: assert property (TORQUE_OFF |-> !MOTOR_OUT_EN && !RUN_ENABLE && !JOG)
    else $error("output energised in torque off");
  AST_REV_RAMP: assert property (REVERSE_AFTER_RAMP == $past(RAMP_SPEED_REF[SW-1]))
    else $error("reverse output wrong");
  AST_VMASTER: assert property (VMASTER_DIR_OUT == $past(VMASTER_DIR))
    else $error("master direction wrong");
  AST_SLS_TRIP: assert property (SLS_REQ && !SLS_RAMP_EN && $signed(MOTOR_SPEED) > $signed(SLS_LIMIT) |=> TORQUE_OFF)
    else $error("speed guard missed");
  AST_SLS_RAMP: assert property ($rose(SLS_REQ) && SLS_RAMP_EN && MOTOR_OUT_EN && !SMS_EN && !TORQUE_OFF_REQ && $signed(MOTOR_SPEED) <= $signed(SLS_LIMIT) |=> RAMP_DOWN)
    else $error("speed guard ramp missed");
  AST_SMS_TRIP: assert property (SMS_EN && $signed(MOTOR_SPEED) > $signed(SMS_LIMIT) |=> TORQUE_OFF)
    else $error("max speed guard missed");
  AST_HOMING: assert property (PROFILE_SEL == 2'h3 |=> STATE_WORD[4] == HOMING_DONE && HOMING_DONE == $past(HOMING_COMPLETE))
    else $error("homing status wrong");
endmodule // mws_motion_word_sva

bind mws_motion_word mws_motion_word_sva #(.SW(SW)) mws_motion_word_sva_i (
  .SYS_CLK(SYS_CLK), .RESETN(RESETN), .TORQUE_OFF_REQ(TORQUE_OFF_REQ),
  .CTRL_STOP_REQ(CTRL_STOP_REQ), .SLS_REQ(SLS_REQ), .SLS_RAMP_EN(SLS_RAMP_EN),
  .SMS_EN(SMS_EN), .PROFILE_SEL(PROFILE_SEL), .VMASTER_DIR(VMASTER_DIR),
  .HOMING_COMPLETE(HOMING_COMPLETE), .RAMP_SPEED_REF(RAMP_SPEED_REF),
  .MOTOR_SPEED(MOTOR_SPEED), .SLS_LIMIT(SLS_LIMIT), .SMS_LIMIT(SMS_LIMIT),
  .STATE_WORD(STATE_WORD), .RUN_ENABLE(RUN_ENABLE), .JOG(JOG),
  .HOMING_DONE(HOMING_DONE), .REVERSE_AFTER_RAMP(REVERSE_AFTER_RAMP),
  .VMASTER_DIR_OUT(VMASTER_DIR_OUT), .MOTOR_OUT_EN(MOTOR_OUT_EN),
  .RAMP_DOWN(RAMP_DOWN), .TORQUE_OFF(TORQUE_OFF));

// [mws_fb_master.sv]
// fieldbus master model that writes the command word and reads state
`timescale 1ns/10ps
module mws_fb_master (
  // clock
  input  wire         SYS_CLK,
  // word interface
  input  wire  [15:0] STATE_WORD,
  output logic [15:0] COMMAND_WORD
);
  // last state word taken by the master
  logic [15:0] seen_state;
  initial COMMAND_WORD = 16'h0000;
  // write: launched just after an edge, then held as a level
  task send(input logic [15:0] w);
    @(posedge SYS_CLK);
    COMMAND_WORD <= w;
  endtask
  // read: waits out the two-cycle path to the on-target bit
  task fetch(output logic [15:0] w);
    repeat (3) @(posedge SYS_CLK);
    #1 w = STATE_WORD;
    seen_state = w;
  endtask
endmodule // mws_fb_master

// [mws_motion_word_tb.sv]
// self-checking testbench of the motion word and safe stop block
`timescale 1ns/10ps
module mws_motion_word_tb;
  localparam PW = 16;
  localparam SW = 16;
  logic SYS_CLK = 1'b0;
  logic RESETN = 1'b0;
  wire [15:0] COMMAND_WORD, STATE_WORD;
  logic [1:0] PROFILE_SEL;
  logic [27:0] CMD_SLOT_SEL;
  logic [14:0] STATE_SLOT_SEL;
  logic SS_VARIANT, SLS_RAMP_EN, SMS_EN, BUS_CONTROL, TORQUE_OFF_REQ;
  logic CTRL_STOP_REQ, SLS_REQ, CONTROL_READY, DRIVE_READY, TRIP, TRIP_LOCK;
  logic WARNING, AUTO_START_STOP, VOLT_EXCEED, TORQUE_EXCEED, TIMER_EXCEED;
  logic HOMING_COMPLETE, SYNC_MODE, SYNC_ALIGNED, VMASTER_DIR;
  logic [PW-1:0] TARGET_POS, AXIS_POS, POS_MIN, POS_MAX, TRACK_ERR, MAX_POS_ERR;
  logic [SW-1:0] RAMP_SPEED_REF, MOTOR_SPEED, SLS_LIMIT, SMS_LIMIT;
  logic [SW-1:0] FREQ_OUT, FREQ_LOW, FREQ_HIGH;
  wire [2:0] PRESET_REF;
  wire [1:0] SETUP_SEL;
  wire [11:0] AUX_FUNC;
  wire [PW-1:0] EFF_TARGET;
  wire RUN_ENABLE, JOG, QUICK_STOP, FAULT_RESET, RELATIVE_POS, DATA_VALID;
  wire REVERSE, HOMING_DONE, ON_TARGET, POS_ERROR, POS_LIMIT, TOUCH_ACTIVE;
  wire TOUCH_ON_TARGET, REVERSE_AFTER_RAMP, VMASTER_DIR_OUT, MOTOR_OUT_EN;
  wire RAMP_DOWN, TORQUE_OFF;
  int fail_count = 0;
  int n_compared = 0;
  // short stop time keeps the time-based stop within a few cycles
  mws_motion_word #(.PW(PW), .SW(SW), .STOP_CYC(8)) mws_motion_word_i (.*);
  mws_fb_master mws_fb_master_i (.*);
  always #5 SYS_CLK = ~SYS_CLK;
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk_w(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_b(input logic got, input logic exp);
    chk_w({15'h0, got}, {15'h0, exp});
  endtask
  // one edge for the registered answer to land
  task tick;
    @(posedge SYS_CLK);
    #1;
  endtask
  // bounded wait for the power stage to drop
  task wait_off(input int lim, output int n);
    n = 0;
    while (TORQUE_OFF !== 1'b1 && n < lim) begin
      tick;
      n++;
    end
    if (TORQUE_OFF !== 1'b1) begin
      fail_count++;
      wrap_up;
    end
  endtask
  // clear requests, let the sequencer idle, then start
  task go_run;
    @(posedge SYS_CLK);
    {TORQUE_OFF_REQ, CTRL_STOP_REQ, SLS_REQ, SMS_EN, SS_VARIANT} <= 5'h00;
    MOTOR_SPEED <= 16'h0000;
    mws_fb_master_i.send(16'h0018);
    tick;
    tick;
    mws_fb_master_i.send(16'h0078);
    tick;
    tick;
    chk_b(MOTOR_OUT_EN, 1'b1);
    chk_b(RUN_ENABLE, 1'b1);
  endtask
  initial begin
    #200us;
    fail_count++;
    wrap_up;
  end
  initial begin
    int n;
    logic [15:0] sw;
    {SS_VARIANT, SLS_RAMP_EN, SMS_EN, TORQUE_OFF_REQ, CTRL_STOP_REQ} = '0;
    {SLS_REQ, TRIP, TRIP_LOCK, WARNING, AUTO_START_STOP, VOLT_EXCEED} = '0;
    {TORQUE_EXCEED, TIMER_EXCEED, HOMING_COMPLETE, SYNC_MODE} = '0;
    {SYNC_ALIGNED, VMASTER_DIR, CMD_SLOT_SEL, STATE_SLOT_SEL} = '0;
    {AXIS_POS, TRACK_ERR, RAMP_SPEED_REF, MOTOR_SPEED, FREQ_LOW} = '0;
    {PROFILE_SEL, BUS_CONTROL, CONTROL_READY, DRIVE_READY} = 5'h1F;
    {TARGET_POS, POS_MAX, POS_MIN} = {16'h0064, 16'h0064, 16'hFF9C};
    {MAX_POS_ERR, SLS_LIMIT, SMS_LIMIT} = {16'h000A, 16'h0064, 16'h00C8};
    {FREQ_OUT, FREQ_HIGH} = {16'h0032, 16'h0064};
    repeat (5) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    repeat (6) @(posedge SYS_CLK);
    // status inputs and discrete direction outputs
    {TRIP, TRIP_LOCK, WARNING, VOLT_EXCEED, VMASTER_DIR} <= 5'h1F;
    {TORQUE_EXCEED, TIMER_EXCEED, AUTO_START_STOP} <= 3'h7;
    RAMP_SPEED_REF <= 16'hFFFB;
    mws_fb_master_i.fetch(sw);
    chk_w(sw & 16'hF7FB, 16'hF6CB);
    chk_b(REVERSE_AFTER_RAMP, 1'b1);
    chk_b(VMASTER_DIR_OUT, 1'b1);
    {TRIP, TRIP_LOCK, WARNING, VOLT_EXCEED, VMASTER_DIR} <= 5'h00;
    {TORQUE_EXCEED, TIMER_EXCEED, AUTO_START_STOP} <= 3'h0;
    {CONTROL_READY, DRIVE_READY, BUS_CONTROL} <= 3'h0;
    FREQ_LOW <= 16'h0040;
    FREQ_HIGH <= 16'h00C7;
    FREQ_OUT <= 16'h00C8;
    HOMING_COMPLETE <= 1'b1;
    mws_fb_master_i.fetch(sw);
    chk_w(sw & 16'h0613, 16'h0010);
    chk_b(HOMING_DONE, 1'b1);
    PROFILE_SEL <= 2'h0;
    mws_fb_master_i.fetch(sw);
    chk_w(sw & 16'h0010, 16'h0000);
    {PROFILE_SEL, HOMING_COMPLETE, FREQ_OUT} <= {2'h3, 1'b0, 16'h0032};
    {CONTROL_READY, DRIVE_READY, BUS_CONTROL} <= 3'h7;
    FREQ_LOW <= 16'h0000;
    // position, touch and reassigned state slots
    {STATE_SLOT_SEL, TRACK_ERR, AXIS_POS} <= {15'h01EC, 16'h0032, 16'h0064};
    mws_fb_master_i.send(16'h1000);
    mws_fb_master_i.fetch(sw);
    chk_w(sw & 16'h3120, 16'h3120);
    chk_b(ON_TARGET, 1'b1);
    chk_b(POS_ERROR, 1'b1);
    chk_b(POS_LIMIT, 1'b1);
    chk_b(TOUCH_ACTIVE, 1'b1);
    chk_b(TOUCH_ON_TARGET, 1'b1);
    {SYNC_MODE, TRACK_ERR, AXIS_POS} <= {1'b1, 16'h0005, 16'h0000};
    MAX_POS_ERR <= 16'h0005;
    mws_fb_master_i.send(16'h0000);
    mws_fb_master_i.fetch(sw);
    chk_b(ON_TARGET, 1'b0);
    chk_b(POS_ERROR, 1'b0);
    chk_b(POS_LIMIT, 1'b0);
    chk_b(TOUCH_ACTIVE, 1'b0);
    {SYNC_ALIGNED, STATE_SLOT_SEL} <= {1'b1, 15'h0000};
    mws_fb_master_i.fetch(sw);
    chk_b(ON_TARGET, 1'b1);
    SYNC_MODE <= 1'b0;
    // command decode, then the default profile
    mws_fb_master_i.send(16'hC68D);
    mws_fb_master_i.fetch(sw);
    chk_w({6'h00, REVERSE, SETUP_SEL, DATA_VALID, RELATIVE_POS, FAULT_RESET,
           QUICK_STOP, PRESET_REF}, 16'h037D);
    PROFILE_SEL <= 2'h0;
    mws_fb_master_i.fetch(sw);
    chk_b(RELATIVE_POS, 1'b0);
    {PROFILE_SEL, CMD_SLOT_SEL} <= {2'h3, 28'h000_B005};
    mws_fb_master_i.send(16'h1001);
    mws_fb_master_i.fetch(sw);
    chk_w({4'h0, AUX_FUNC}, 16'h0A00);
    chk_w(EFF_TARGET, 16'hFF9C);
    CMD_SLOT_SEL <= 28'h000_0000;
    // torque off cuts power and holds against run commands
    go_run;
    TORQUE_OFF_REQ <= 1'b1;
    tick;
    chk_b(TORQUE_OFF, 1'b1);
    chk_b(MOTOR_OUT_EN, 1'b0);
    TORQUE_OFF_REQ <= 1'b0;
    mws_fb_master_i.send(16'h0178);
    mws_fb_master_i.fetch(sw);
    chk_b(RUN_ENABLE, 1'b0);
    chk_b(JOG, 1'b0);
    // controlled stop, ramp variant then time variant
    for (int v = 0; v < 2; v++) begin
      go_run;
      {SS_VARIANT, CTRL_STOP_REQ, MOTOR_SPEED} <= {v[0], 1'b1, 16'h0032};
      tick;
      chk_b(RAMP_DOWN, 1'b1);
      chk_b(TORQUE_OFF, 1'b0);
      if (v == 0) begin
        repeat (4) @(posedge SYS_CLK);
        MOTOR_SPEED <= 16'h0000;
      end
      wait_off(40, n);
      chk_w(n[15:0], (v == 0) ? 16'h0001 : 16'h0008);
    end
    // speed guards
    go_run;
    {SLS_REQ, MOTOR_SPEED} <= {1'b1, 16'h0096};
    tick;
    chk_b(TORQUE_OFF, 1'b1);
    go_run;
    {SLS_RAMP_EN, SLS_REQ, MOTOR_SPEED} <= {2'h3, 16'h0032};
    tick;
    chk_b(RAMP_DOWN, 1'b1);
    chk_b(TORQUE_OFF, 1'b0);
    go_run;
    {SLS_RAMP_EN, SMS_EN, MOTOR_SPEED} <= {2'h1, 16'h00FA};
    tick;
    chk_b(TORQUE_OFF, 1'b1);
    wrap_up;
  end
endmodule // mws_motion_word_tb
